// *** hdl/spr_regs.sv ***
// spr_regs: register file, interrupt encoding and DMA pointers of the serial port
// assumes: core accesses are single-cycle strobes on clock; line events are same-clock pulses
`timescale 1ns/1ps

// Overview of operation
// - unit 0 on page 24, unit 1 on 25
// - data buffers share F8h, separate read/write registers
// - rx counter pointer bits 7:1 to DMA
// - rx counter bit 0: memory or register file
// - rx address pointer bits 7:1 to DMA
// - rx address bit 0 picks extension segment
// - tx counter pointer location and source select
// - tx address pointer and extension segment select
// - vector bits 7:3 software base
// - vector bits 2:1 hardware source code only
// - source codes: error, address/break, data, transmit
// - vector bit 0 reads zero
// - addressed modes compare word, set address pending
// - after address pending pass data words
// - mask bit 7 selects empty source
// - rx block done set by hardware, software clears
// - tx block done set by hardware, software clears
// - mask bit 4 gates receive errors
// - mask bit 3 gates address pending
// - mask bit 2 gates break pending
// - mask bit 1 gates data and rx done
// - mask bit 0 gates transmit empty sources
// - priority: rx DMA, tx DMA, rx irq, tx irq
// - DMA active swaps sources for block done; tx only with mask bit 7 clear
module spr_regs import spr_pkg::*; #(
    parameter logic UNIT = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire spr_bus_t bus,
    input wire spr_evt_t evt,
    output logic [7:0] rdata,
    output logic [7:0] tx_data,
    output logic tx_load,
    output logic irq,
    output logic [7:0] irq_vector,
    output spr_dma_t dma,
    output logic [7:0] mask_out
);
    spr_state_t state_reg, state_next;
    logic sel, rd_hit, wr_hit;
    logic [7:0] gated;
    logic rx_dma_on, tx_dma_on, addr_mode, is_match, rx_err_irq, addr_irq, rx_irq, tx_irq;
    logic tx_empty_src;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        sel = bus.page == (UNIT ? SPR_PAGE_UNIT1 : SPR_PAGE_UNIT0);
        rd_hit = sel && bus.rd;
        wr_hit = sel && bus.wr;
        rx_dma_on = state_reg.priority_r[SPR_PRI_RX_DMA];
        tx_dma_on = state_reg.priority_r[SPR_PRI_TX_DMA];
        // any of the three address / search modes is active once either enable is set
        addr_mode = state_reg.priority_r[SPR_PRI_ADDR_EN] || state_reg.char_fmt[SPR_CHF_ADDR_MODE];
        is_match = evt.word == state_reg.match_char;
        case ({state_reg.priority_r[SPR_PRI_ADDR_EN], state_reg.char_fmt[SPR_CHF_ADDR_MODE]})
            2'h0: is_match = evt.ninth_bit;
            2'h1: is_match = evt.word == state_reg.match_char;
            2'h2: is_match = evt.ninth_bit && evt.word == state_reg.match_char;
            default: is_match = evt.after_break && evt.word == state_reg.match_char;
        endcase
        state_next = state_reg;
        state_next.tx_load = 1'b0;
        // software writes first; hardware sets below win over a clear in the same cycle
        if (wr_hit) begin
            if (bus.addr == SPR_OFF_RX_CNT_PTR) begin
                state_next.rx_cnt_ptr = bus.wdata;
            end else if (bus.addr == SPR_OFF_RX_ADR_PTR) begin
                state_next.rx_adr_ptr = bus.wdata;
            end else if (bus.addr == SPR_OFF_TX_CNT_PTR) begin
                state_next.tx_cnt_ptr = bus.wdata;
            end else if (bus.addr == SPR_OFF_TX_ADR_PTR) begin
                state_next.tx_adr_ptr = bus.wdata;
            end else if (bus.addr == SPR_OFF_VECTOR) begin
                state_next.vec_base = bus.wdata[7:3];
            end else if (bus.addr == SPR_OFF_MATCH) begin
                state_next.match_char = bus.wdata;
            end else if (bus.addr == SPR_OFF_MASK) begin
                // done flags only clear from software, never set
                state_next.mask = {bus.wdata[7], state_reg.mask[6] & bus.wdata[6],
                    state_reg.mask[5] & bus.wdata[5], bus.wdata[4:0]};
            end else if (bus.addr == SPR_OFF_PENDING) begin
                state_next.pending = state_reg.pending & bus.wdata;
            end else if (bus.addr == SPR_OFF_DATA) begin
                state_next.tx_buf = bus.wdata;
                state_next.tx_load = 1'b1;
            end else if (bus.addr == SPR_OFF_PRIORITY) begin
                state_next.priority_r = bus.wdata;
            end else if (bus.addr == SPR_OFF_CHAR_FMT) begin
                state_next.char_fmt = bus.wdata;
            end else if (bus.addr == SPR_OFF_CLK_SETUP) begin
                state_next.clk_setup = bus.wdata;
            end else if (bus.addr == SPR_OFF_BAUD_HI) begin
                state_next.baud_hi = bus.wdata;
            end else if (bus.addr == SPR_OFF_BAUD_LO) begin
                state_next.baud_lo = bus.wdata;
            end else if (bus.addr == SPR_OFF_SYNC_IN) begin
                state_next.sync_in = bus.wdata;
            end else if (bus.addr == SPR_OFF_SYNC_OUT) begin
                state_next.sync_out = bus.wdata;
            end
        end
        // hardware event sets
        if (evt.overrun) state_next.pending[SPR_PND_OVERRUN] = 1'b1;
        if (evt.framing) state_next.pending[SPR_PND_FRAMING] = 1'b1;
        if (evt.parity) state_next.pending[SPR_PND_PARITY] = 1'b1;
        if (evt.brk) state_next.pending[SPR_PND_BREAK] = 1'b1;
        if (evt.buf_empty) state_next.pending[SPR_PND_BUF_EMPTY] = 1'b1;
        if (evt.shift_empty) state_next.pending[SPR_PND_SHIFT_EMPTY] = 1'b1;
        if (evt.rx_dma_eob) state_next.mask[SPR_MSK_RX_DONE] = 1'b1;
        if (evt.tx_dma_eob) state_next.mask[SPR_MSK_TX_DONE] = 1'b1;
        if (evt.word_valid) begin
            if (!addr_mode) begin
                state_next.rx_buf = evt.word;
                state_next.pending[SPR_PND_RX_DATA] = 1'b1;
            end else if (is_match) begin
                // the address word itself is not buffered
                state_next.pending[SPR_PND_ADDR] = 1'b1;
                state_next.addr_seen = 1'b1;
            end else if (state_reg.addr_seen && !evt.ninth_bit) begin
                state_next.rx_buf = evt.word;
                state_next.pending[SPR_PND_RX_DATA] = 1'b1;
            end else begin
                // an unmatched address closes the window
                state_next.addr_seen = 1'b0;
            end
        end
        // source gating
        gated = state_reg.pending;
        tx_empty_src = state_reg.mask[SPR_MSK_EMPTY_SEL] ? gated[SPR_PND_BUF_EMPTY]
            : gated[SPR_PND_SHIFT_EMPTY];
        rx_err_irq = state_reg.mask[SPR_MSK_RX_ERR]
            && |gated[SPR_PND_OVERRUN:SPR_PND_PARITY];
        addr_irq = (state_reg.mask[SPR_MSK_ADDR] && gated[SPR_PND_ADDR])
            || (state_reg.mask[SPR_MSK_BREAK] && gated[SPR_PND_BREAK]);
        // with DMA active, data pending feeds DMA and the done flag takes its place
        rx_irq = state_reg.mask[SPR_MSK_RX_DATA] && (rx_dma_on ? state_reg.mask[SPR_MSK_RX_DONE]
            : (gated[SPR_PND_RX_DATA] || state_reg.mask[SPR_MSK_RX_DONE]));
        tx_irq = state_reg.mask[SPR_MSK_TX_DATA] && ((tx_dma_on && !state_reg.mask[SPR_MSK_EMPTY_SEL])
            ? state_reg.mask[SPR_MSK_TX_DONE]
            : (tx_empty_src || state_reg.mask[SPR_MSK_TX_DONE]));
        // DMA requests are not gated by the data masks
        state_next.dma.rx_req = rx_dma_on && gated[SPR_PND_RX_DATA];
        state_next.dma.tx_req = tx_dma_on && !state_reg.mask[SPR_MSK_EMPTY_SEL]
            && gated[SPR_PND_SHIFT_EMPTY];
        state_next.dma.rx_cnt_loc = state_reg.rx_cnt_ptr[7:1];
        state_next.dma.rx_to_regfile = state_reg.rx_cnt_ptr[0];
        state_next.dma.rx_ptr_loc = state_reg.rx_adr_ptr[7:1];
        // extension select has no meaning when the register file is the target
        state_next.dma.rx_dma_seg = !state_reg.rx_cnt_ptr[0] && state_reg.rx_adr_ptr[0];
        state_next.dma.tx_cnt_loc = state_reg.tx_cnt_ptr[7:1];
        state_next.dma.tx_from_regfile = state_reg.tx_cnt_ptr[0];
        state_next.dma.tx_ptr_loc = state_reg.tx_adr_ptr[7:1];
        state_next.dma.tx_dma_seg = !state_reg.tx_cnt_ptr[0] && state_reg.tx_adr_ptr[0];
        // service order; the code is held while nothing is pending
        state_next.srv = SPR_SRV_NONE;
        if (rx_err_irq) begin
            state_next.vec_code = SPR_EV_RX_ERR;
        end else if (addr_irq) begin
            state_next.vec_code = SPR_EV_ADDR_BRK;
        end else if (rx_irq) begin
            state_next.vec_code = SPR_EV_RX_DATA;
        end else if (tx_irq) begin
            state_next.vec_code = SPR_EV_TX;
        end
        // a pending DMA request delays the interrupt cycle, not its source code,
        // so a raised irq never shows a stale code
        if (state_next.dma.rx_req) begin
            state_next.srv = SPR_SRV_RX_DMA;
        end else if (state_next.dma.tx_req) begin
            state_next.srv = SPR_SRV_TX_DMA;
        end else if (rx_err_irq || addr_irq || rx_irq || tx_irq) begin
            state_next.srv = SPR_SRV_IRQ;
        end
        state_next.irq = rx_err_irq || addr_irq || rx_irq || tx_irq;
        state_next.irq_vector = {state_next.vec_base, state_next.vec_code, 1'b0};
        // read data, registered
        state_next.rdata = 8'h00;
        if (rd_hit) begin
            if (bus.addr == SPR_OFF_RX_CNT_PTR) begin
                state_next.rdata = state_reg.rx_cnt_ptr;
            end else if (bus.addr == SPR_OFF_RX_ADR_PTR) begin
                state_next.rdata = state_reg.rx_adr_ptr;
            end else if (bus.addr == SPR_OFF_TX_CNT_PTR) begin
                state_next.rdata = state_reg.tx_cnt_ptr;
            end else if (bus.addr == SPR_OFF_TX_ADR_PTR) begin
                state_next.rdata = state_reg.tx_adr_ptr;
            end else if (bus.addr == SPR_OFF_VECTOR) begin
                state_next.rdata = {state_reg.vec_base, state_reg.vec_code, 1'b0};
            end else if (bus.addr == SPR_OFF_MATCH) begin
                state_next.rdata = state_reg.match_char;
            end else if (bus.addr == SPR_OFF_MASK) begin
                state_next.rdata = state_reg.mask;
            end else if (bus.addr == SPR_OFF_PENDING) begin
                state_next.rdata = state_reg.pending;
            end else if (bus.addr == SPR_OFF_DATA) begin
                state_next.rdata = state_reg.rx_buf;
            end else if (bus.addr == SPR_OFF_PRIORITY) begin
                state_next.rdata = state_reg.priority_r;
            end else if (bus.addr == SPR_OFF_CHAR_FMT) begin
                state_next.rdata = state_reg.char_fmt;
            end else if (bus.addr == SPR_OFF_CLK_SETUP) begin
                state_next.rdata = state_reg.clk_setup;
            end else if (bus.addr == SPR_OFF_BAUD_HI) begin
                state_next.rdata = state_reg.baud_hi;
            end else if (bus.addr == SPR_OFF_BAUD_LO) begin
                state_next.rdata = state_reg.baud_lo;
            end else if (bus.addr == SPR_OFF_SYNC_IN) begin
                state_next.rdata = state_reg.sync_in;
            end else if (bus.addr == SPR_OFF_SYNC_OUT) begin
                state_next.rdata = state_reg.sync_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.mask <= SPR_RST_MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign tx_data = state_reg.tx_buf;
    assign tx_load = state_reg.tx_load;
    assign irq = state_reg.irq;
    assign irq_vector = state_reg.irq_vector;
    assign dma = state_reg.dma;
    assign mask_out = state_reg.mask;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    vec_zero_a: assert property (irq_vector[0] == 1'b0 && rdata[0] == 1'b0 || !$past(rd_hit && bus.addr == SPR_OFF_VECTOR) && irq_vector[0] == 1'b0) else $error("vector bit 0 not zero");
    vec_base_a: assert property (wr_hit && bus.addr == SPR_OFF_VECTOR |=> state_reg.vec_base == $past(bus.wdata[7:3])) else $error("vector base not written");
    rx_done_set_a: assert property (evt.rx_dma_eob |=> mask_out[SPR_MSK_RX_DONE]) else $error("rx done not set");
    tx_done_set_a: assert property (evt.tx_dma_eob |=> mask_out[SPR_MSK_TX_DONE]) else $error("tx done not set");
    rx_done_hold_a: assert property (mask_out[SPR_MSK_RX_DONE] && !(wr_hit && bus.addr == SPR_OFF_MASK) |=> mask_out[SPR_MSK_RX_DONE]) else $error("rx done lost");
    err_gate_a: assert property (!mask_out[SPR_MSK_RX_ERR] && !mask_out[SPR_MSK_ADDR] && !mask_out[SPR_MSK_BREAK] && !mask_out[SPR_MSK_RX_DATA] && !mask_out[SPR_MSK_TX_DATA] |=> !irq) else $error("irq while all masked");
    err_code_a: assert property (mask_out[SPR_MSK_RX_ERR] && |state_reg.pending[7:5] && !state_next.dma.rx_req && !state_next.dma.tx_req |=> irq && irq_vector[2:1] == SPR_EV_RX_ERR) else $error("error code wrong");
    dma_ptr_a: assert property (##1 dma.rx_cnt_loc == $past(state_reg.rx_cnt_ptr[7:1])) else $error("rx counter location wrong");
    dma_prio_a: assert property (state_next.dma.rx_req |=> state_reg.srv == SPR_SRV_RX_DMA) else $error("rx dma not first");
    addr_set_a: assert property (evt.word_valid && state_reg.char_fmt[SPR_CHF_ADDR_MODE] && !state_reg.priority_r[SPR_PRI_ADDR_EN] && evt.word == state_reg.match_char |=> state_reg.pending[SPR_PND_ADDR]) else $error("address pending not set");

    rx_dma_c: cover property (state_reg.srv == SPR_SRV_RX_DMA);
    tx_irq_c: cover property (irq && irq_vector[2:1] == SPR_EV_TX);
    addr_c: cover property (state_reg.addr_seen ##[1:20] evt.word_valid);
endmodule // spr_regs

// *** shared/spr_pkg.sv ***
// spr_pkg: constants, types and register layout of the serial-port register block
// assumes: byte-wide paged register file access from the core, one clock domain
package spr_pkg;
    // register pages of the first and second unit
    localparam logic [7:0] SPR_PAGE_UNIT0 = 8'h18;
    localparam logic [7:0] SPR_PAGE_UNIT1 = 8'h19;
    // register offsets within the page
    localparam logic [7:0] SPR_OFF_RX_CNT_PTR = 8'hf0;
    localparam logic [7:0] SPR_OFF_RX_ADR_PTR = 8'hf1;
    localparam logic [7:0] SPR_OFF_TX_CNT_PTR = 8'hf2;
    localparam logic [7:0] SPR_OFF_TX_ADR_PTR = 8'hf3;
    localparam logic [7:0] SPR_OFF_VECTOR = 8'hf4;
    localparam logic [7:0] SPR_OFF_MATCH = 8'hf5;
    localparam logic [7:0] SPR_OFF_MASK = 8'hf6;
    localparam logic [7:0] SPR_OFF_PENDING = 8'hf7;
    localparam logic [7:0] SPR_OFF_DATA = 8'hf8;
    localparam logic [7:0] SPR_OFF_PRIORITY = 8'hf9;
    localparam logic [7:0] SPR_OFF_CHAR_FMT = 8'hfa;
    localparam logic [7:0] SPR_OFF_CLK_SETUP = 8'hfb;
    localparam logic [7:0] SPR_OFF_BAUD_HI = 8'hfc;
    localparam logic [7:0] SPR_OFF_BAUD_LO = 8'hfd;
    localparam logic [7:0] SPR_OFF_SYNC_IN = 8'hfe;
    localparam logic [7:0] SPR_OFF_SYNC_OUT = 8'hff;
    // mask register bit positions
    localparam int SPR_MSK_EMPTY_SEL = 7;
    localparam int SPR_MSK_RX_DONE = 6;
    localparam int SPR_MSK_TX_DONE = 5;
    localparam int SPR_MSK_RX_ERR = 4;
    localparam int SPR_MSK_ADDR = 3;
    localparam int SPR_MSK_BREAK = 2;
    localparam int SPR_MSK_RX_DATA = 1;
    localparam int SPR_MSK_TX_DATA = 0;
    // pending register bit positions
    localparam int SPR_PND_OVERRUN = 7;
    localparam int SPR_PND_FRAMING = 6;
    localparam int SPR_PND_PARITY = 5;
    localparam int SPR_PND_ADDR = 4;
    localparam int SPR_PND_BREAK = 3;
    localparam int SPR_PND_RX_DATA = 2;
    localparam int SPR_PND_BUF_EMPTY = 1;
    localparam int SPR_PND_SHIFT_EMPTY = 0;
    // priority and character format register fields
    localparam int SPR_PRI_ADDR_EN = 7;
    localparam int SPR_PRI_RX_DMA = 4;
    localparam int SPR_PRI_TX_DMA = 3;
    localparam int SPR_CHF_ADDR_MODE = 2;
    // reset values
    localparam logic [7:0] SPR_RST_MASK = 8'h00;
    localparam logic [7:0] SPR_RST_ZERO = 8'h00;
    // encoded interrupt source codes
    localparam logic [1:0] SPR_EV_RX_ERR = 2'h0;
    localparam logic [1:0] SPR_EV_ADDR_BRK = 2'h1;
    localparam logic [1:0] SPR_EV_RX_DATA = 2'h2;
    localparam logic [1:0] SPR_EV_TX = 2'h3;

    typedef enum logic [1:0] {SPR_SRV_NONE, SPR_SRV_RX_DMA, SPR_SRV_TX_DMA, SPR_SRV_IRQ} spr_srv_t;

    // core side register access
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } spr_bus_t;

    // events from the serial line logic, one-cycle pulses
    typedef struct packed {
        logic overrun;
        logic framing;
        logic parity;
        logic brk;
        logic word_valid;
        logic [7:0] word;
        logic ninth_bit;
        logic after_break;
        logic buf_empty;
        logic shift_empty;
        logic rx_dma_eob;
        logic tx_dma_eob;
    } spr_evt_t;

    // DMA controller view
    typedef struct packed {
        logic rx_req;
        logic [6:0] rx_cnt_loc;
        logic rx_to_regfile;
        logic [6:0] rx_ptr_loc;
        logic rx_dma_seg;
        logic tx_req;
        logic [6:0] tx_cnt_loc;
        logic tx_from_regfile;
        logic [6:0] tx_ptr_loc;
        logic tx_dma_seg;
    } spr_dma_t;

    typedef struct packed {
        logic [7:0] rx_cnt_ptr;
        logic [7:0] rx_adr_ptr;
        logic [7:0] tx_cnt_ptr;
        logic [7:0] tx_adr_ptr;
        logic [4:0] vec_base;
        logic [1:0] vec_code;
        logic [7:0] match_char;
        logic [7:0] mask;
        logic [7:0] pending;
        logic [7:0] rx_buf;
        logic [7:0] tx_buf;
        logic tx_load;
        logic [7:0] priority_r;
        logic [7:0] char_fmt;
        logic [7:0] clk_setup;
        logic [7:0] baud_hi;
        logic [7:0] baud_lo;
        logic [7:0] sync_in;
        logic [7:0] sync_out;
        logic addr_seen;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] irq_vector;
        spr_srv_t srv;
        spr_dma_t dma;
    } spr_state_t;
endpackage

// *** test/spr_host_model.sv ***
// spr_host_model: core-side partner issuing byte reads and writes on the paged bus
// assumes: the block samples its strobes on the rising edge of clock
`timescale 1ns/1ps
module spr_host_model import spr_pkg::*; (
    input wire logic clock,
    output spr_bus_t bus,
    input wire logic [7:0] rdata
);
    // page of the unit being addressed, changed by the bench
    logic [7:0] page = SPR_PAGE_UNIT0;
    initial bus = '0;
    ////////////////////////////////////////////////////////////
    // writing 0 to a done or pending bit is the only way software clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{page: page, addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(posedge clock);
        bus.wr <= 1'b0;
        // address scrambled once released so stale values cannot pass for good ones
        bus.addr <= ~a;
        bus.wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{page: page, addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge clock);
        bus.rd <= 1'b0;
        bus.addr <= ~a;
        @(negedge clock);
        d = rdata;
    endtask
endmodule // spr_host_model

// *** test/test_serial_port_irq_dma_registers.sv ***
// test_serial_port_irq_dma_registers: self-checking bench for spr_regs
// assumes: spr_host_model drives the core bus; line events are driven from here
`timescale 1ns/1ps
module test_serial_port_irq_dma_registers;
    import spr_pkg::*;
    logic clock, rst;
    spr_bus_t bus;
    spr_evt_t evt, e;
    logic [7:0] rdata, tx_data, irq_vector, mask_out, d, v;
    logic tx_load, irq;
    spr_dma_t dma;
    int err_total, compares;
    logic [31:0] seed = 32'hb3c4;
    logic [7:0] mdl [16];
    logic [7:0] offs [12] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf5, 8'hf9, 8'hfa, 8'hfb,
        8'hfc, 8'hfd, 8'hfe, 8'hff};
    logic [7:0] msk [4] = '{8'h10, 8'h04, 8'h02, 8'h01};
    int pnd [4] = '{7, 3, 2, 0};
    spr_regs spr_regs_inst(.clock(clock), .rst(rst), .bus(bus), .evt(evt), .rdata(rdata),
        .tx_data(tx_data), .tx_load(tx_load), .irq(irq), .irq_vector(irq_vector),
        .dma(dma), .mask_out(mask_out));
    spr_host_model spr_host_model_inst(.clock(clock), .bus(bus), .rdata(rdata));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        spr_host_model_inst.wr(a, x);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        spr_host_model_inst.rd(a, d);
        chk_rd(d, exp);
    endtask
    // event lasts one cycle; irq lags it by two, so three edges are enough
    task automatic pulse(input spr_evt_t p);
        @(posedge clock);
        evt <= p;
        @(posedge clock);
        evt <= '0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        evt = '0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        chk_pin(mask_out, 8'h00);
        rst <= 1'b0;
        foreach (offs[i]) begin
            mdl[offs[i][3:0]] = rnd();
            // keep addressed mode and DMA off so the source tests see plain flags
            if (offs[i] == SPR_OFF_PRIORITY) mdl[9] = mdl[9] & 8'h67;
            if (offs[i] == SPR_OFF_CHAR_FMT) mdl[10] = mdl[10] & 8'hfb;
            wr(offs[i], mdl[offs[i][3:0]]);
        end
        foreach (offs[i]) rchk(offs[i], mdl[offs[i][3:0]]);
        chk_pin({dma.rx_cnt_loc, dma.rx_to_regfile}, mdl[0]);
        // the extension select means nothing when the register file is the target
        chk_pin({dma.rx_ptr_loc, dma.rx_dma_seg}, {mdl[1][7:1], mdl[1][0] & ~mdl[0][0]});
        chk_pin({dma.tx_cnt_loc, dma.tx_from_regfile}, mdl[2]);
        chk_pin({dma.tx_ptr_loc, dma.tx_dma_seg}, {mdl[3][7:1], mdl[3][0] & ~mdl[2][0]});
        spr_host_model_inst.page = SPR_PAGE_UNIT1;
        wr(SPR_OFF_MATCH, ~mdl[5]);
        spr_host_model_inst.page = SPR_PAGE_UNIT0;
        rchk(SPR_OFF_MATCH, mdl[5]);
        $display("register test done");
        v = rnd();
        wr(SPR_OFF_VECTOR, v);
        rchk(SPR_OFF_VECTOR, {v[7:3], 3'b000});
        d = rnd();
        wr(SPR_OFF_DATA, d);
        #1;
        chk_pin({7'h00, tx_load}, 8'h01);
        chk_pin(tx_data, d);
        rchk(SPR_OFF_DATA, 8'h00);
        $display("vector and buffer test done");
        for (int i = 0; i < 4; i++) begin
            wr(SPR_OFF_MASK, 8'h00);
            e = '0;
            e.word = rnd();
            case (i)
                0: e.overrun = 1'b1;
                1: e.brk = 1'b1;
                2: e.word_valid = 1'b1;
                default: e.shift_empty = 1'b1;
            endcase
            pulse(e);
            chk_pin({7'h00, irq}, 8'h00);
            wr(SPR_OFF_MASK, msk[i]);
            repeat (2) @(posedge clock);
            #1;
            chk_pin({7'h00, irq}, 8'h01);
            chk_pin(irq_vector, {v[7:3], i[1:0], 1'b0});
            rchk(SPR_OFF_PENDING, 8'h01 << pnd[i]);
            if (i == 2) rchk(SPR_OFF_DATA, e.word);
            wr(SPR_OFF_PENDING, 8'h00);
            repeat (3) @(posedge clock);
            #1;
            chk_pin({7'h00, irq}, 8'h00);
        end
        wr(SPR_OFF_MASK, 8'h11);
        e = '0;
        e.overrun = 1'b1;
        e.shift_empty = 1'b1;
        pulse(e);
        chk_pin(irq_vector, {v[7:3], 3'b000});
        wr(SPR_OFF_PENDING, 8'h00);
        $display("source test done");
        for (int j = 0; j < 2; j++) begin
            e = '0;
            e.rx_dma_eob = (j == 0);
            e.tx_dma_eob = (j == 1);
            pulse(e);
            chk_pin(mask_out & 8'h60, (j == 1) ? 8'h20 : 8'h40);
            wr(SPR_OFF_MASK, 8'h00);
            #1;
            chk_pin(mask_out, 8'h00);
        end
        $display("block done test done");
        // character search: the match is flagged, the next word is buffered
        wr(SPR_OFF_CHAR_FMT, mdl[10] | 8'h04);
        e = '0;
        e.word_valid = 1'b1;
        e.word = mdl[5];
        pulse(e);
        e.word = ~mdl[5];
        pulse(e);
        rchk(SPR_OFF_PENDING, 8'h14);
        rchk(SPR_OFF_DATA, ~mdl[5]);
        wr(SPR_OFF_CHAR_FMT, mdl[10]);
        wr(SPR_OFF_PENDING, 8'h00);
        $display("address test done");
        // both DMA channels on: data and shift empty feed DMA, block done takes the irq
        wr(SPR_OFF_PRIORITY, mdl[9] | 8'h18);
        wr(SPR_OFF_MASK, 8'h03);
        e = '0;
        e.word_valid = 1'b1;
        e.word = rnd();
        e.shift_empty = 1'b1;
        pulse(e);
        chk_pin({6'h00, dma.rx_req, dma.tx_req}, 8'h03);
        chk_pin({7'h00, irq}, 8'h00);
        e = '0;
        e.rx_dma_eob = 1'b1;
        pulse(e);
        chk_pin({7'h00, irq}, 8'h01);
        chk_pin(irq_vector, {v[7:3], 3'b100});
        $display("dma test done");
        test_done();
    end
endmodule // test_serial_port_irq_dma_registers
